// File: common/mtw_pkg.sv
package mtw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register selectors on the coprocessor write port
  localparam logic [3:0] MTW_SEL_CONTROL = 4'h1;
  localparam logic [3:0] MTW_SEL_TABLE_BASE = 4'h2;
  localparam logic [3:0] MTW_SEL_DOMAIN = 4'h3;
  localparam logic [3:0] MTW_SEL_FLUSH = 4'h5;
  localparam logic [3:0] MTW_SEL_PURGE = 4'h6;

  // Reset values: the MMU comes up disabled
  localparam logic [31:0] MTW_CONTROL_RESET = 32'h0000_0000;
  localparam logic [17:0] MTW_TABLE_BASE_RESET = 18'h0_0000;
  localparam logic [31:0] MTW_DOMAIN_RESET = 32'h0000_0000;

  // Control register bit positions
  localparam int MTW_CTRL_MMU_EN = 0;
  localparam int MTW_CTRL_CACHE_EN = 2;
  localparam int MTW_CTRL_WBUF_EN = 3;
  localparam int MTW_CTRL_SYS = 8;
  localparam int MTW_CTRL_ROM = 9;

  // Table base keeps only bits 31:14
  localparam int MTW_BASE_LSB = 14;
  localparam logic [13:0] MTW_BASE_ZERO = 14'h0000;

  // Descriptor fields
  localparam int MTW_DESC_B = 2;
  localparam int MTW_DESC_C = 3;
  localparam int MTW_DOM_LSB = 5;
  localparam int MTW_AP_LSB = 10;
  localparam int MTW_SUBAP_LSB = 4;
  localparam int MTW_PT_BASE_LSB = 10;

  // Descriptor type codes in bits 1:0
  localparam logic [1:0] MTW_L1_FAULT = 2'b00;
  localparam logic [1:0] MTW_L1_PAGE = 2'b01;
  localparam logic [1:0] MTW_L1_SECTION = 2'b10;
  localparam logic [1:0] MTW_L2_LARGE = 2'b01;
  localparam logic [1:0] MTW_L2_SMALL = 2'b10;

  // Domain field codes
  localparam logic [1:0] MTW_DOM_NONE = 2'b00;
  localparam logic [1:0] MTW_DOM_CLIENT = 2'b01;
  localparam logic [1:0] MTW_DOM_RESVD = 2'b10;
  localparam logic [1:0] MTW_DOM_MANAGER = 2'b11;

  // Access permission codes
  localparam logic [1:0] MTW_AP_PROT = 2'b00;
  localparam logic [1:0] MTW_AP_SUP = 2'b01;
  localparam logic [1:0] MTW_AP_USER_RO = 2'b10;
  localparam logic [1:0] MTW_AP_FULL = 2'b11;

  // Fault status codes
  localparam logic [3:0] MTW_FS_NONE = 4'h0;
  localparam logic [3:0] MTW_FS_TRANS_SECT = 4'h5;
  localparam logic [3:0] MTW_FS_TRANS_PAGE = 4'h7;
  localparam logic [3:0] MTW_FS_DOM_SECT = 4'h9;
  localparam logic [3:0] MTW_FS_DOM_PAGE = 4'hb;
  localparam logic [3:0] MTW_FS_PERM_SECT = 4'hd;
  localparam logic [3:0] MTW_FS_PERM_PAGE = 4'hf;

  // TLB size
  localparam int MTW_TLB_ENTRIES = 64;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    MTW_MAP_SECTION = 2'b00,
    MTW_MAP_LARGE = 2'b01,
    MTW_MAP_SMALL = 2'b10
  } mtw_map_kind_type;

  typedef enum logic [2:0] {
    MTW_ST_IDLE = 3'b000,
    MTW_ST_LOOK = 3'b001,
    MTW_ST_L1 = 3'b011,
    MTW_ST_L2 = 3'b010,
    MTW_ST_CHECK = 3'b110
  } mtw_walk_state_type;

  typedef struct packed {
    logic valid;
    mtw_map_kind_type kind;
    logic [19:0] vtag;
    logic [19:0] ppn;
    logic [3:0] domain;
    logic cacheable;
    logic bufferable;
    logic [7:0] perm;
  } mtw_tlb_entry_type;

  typedef struct packed {
    logic valid;
    logic [31:0] vaddr;
    logic write;
    logic user;
    logic data;
  } mtw_request_type;

  typedef struct packed {
    logic valid;
    logic [31:0] paddr;
    logic fault;
    logic [3:0] status;
    logic [3:0] domain;
    logic cacheable;
    logic bufferable;
  } mtw_response_type;

  typedef struct packed {
    logic wr;
    logic [3:0] sel;
    logic [31:0] data;
  } mtw_cfg_write_type;

  ////////////////////////////////////////////////////////////////////////////
  // Entry matches a virtual address at its own mapping granularity
  function automatic logic mtw_entry_match(input mtw_tlb_entry_type ent, input logic [31:0] va);
    logic m;
    m = 1'b0;
    unique case (ent.kind)
      MTW_MAP_SECTION: m = (ent.vtag[19:8] == va[31:20]);
      MTW_MAP_LARGE: m = (ent.vtag[19:4] == va[31:16]);
      MTW_MAP_SMALL: m = (ent.vtag == va[31:12]);
      default: m = 1'b0;
    endcase
    return ent.valid & m;
  endfunction : mtw_entry_match

endpackage : mtw_pkg

// File: logic/mtw_tlb.sv
`timescale 1ns/1ps
module mtw_tlb #(
  parameter int ENTRIES = 64
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [31:0] lookup_va_i,
  output logic lookup_hit_o,
  output mtw_pkg::mtw_tlb_entry_type lookup_entry_o,
  input wire logic fill_i,
  input wire mtw_pkg::mtw_tlb_entry_type fill_entry_i,
  input wire logic flush_i,
  input wire logic purge_i,
  input wire logic [31:0] purge_va_i
);
  import mtw_pkg::*;

  localparam int IDXW = $clog2(ENTRIES);

  typedef struct packed {
    mtw_tlb_entry_type [ENTRIES-1:0] slot;
    logic [IDXW-1:0] victim;
  } mtw_tlb_state_type;

  mtw_tlb_state_type state_reg;
  mtw_tlb_state_type state_next;
  logic [ENTRIES-1:0] hit_vec;
  logic [ENTRIES-1:0] purge_vec;

  ////////////////////////////////////////////////////////////////////////////
  // Parallel compare of every slot
  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi++)
    begin : g_match
      assign hit_vec[gi] = mtw_entry_match(state_reg.slot[gi], lookup_va_i);
      assign purge_vec[gi] = mtw_entry_match(state_reg.slot[gi], purge_va_i);
    end
  endgenerate

  // Lowest matching slot wins; duplicates cannot arise since fills follow misses
  always_comb
  begin
    lookup_hit_o = |hit_vec;
    lookup_entry_o = '0;
    for (int i = ENTRIES - 1; i >= 0; i--)
    begin
      if (hit_vec[i])
      begin
        lookup_entry_o = state_reg.slot[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flush and purge first, then a fill lands on top
  always_comb
  begin
    state_next = state_reg;
    for (int i = 0; i < ENTRIES; i++)
    begin
      if (flush_i || (purge_i && purge_vec[i]))
      begin
        state_next.slot[i].valid = 1'b0;
      end
    end
    if (fill_i)
    begin
      state_next.slot[state_reg.victim] = fill_entry_i;
      state_next.victim = state_reg.victim + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

endmodule : mtw_tlb

// File: logic/mtw_walker.sv
// Notes on behaviour
// - A table walk starts only after the TLB misses the virtual address.
// - Table base keeps its low fourteen bits zero, 16K aligned.
// - First fetch word address is base 31:14 joined with address 31:20.
// - First level type: 00 fault, 01 page table, 10 section, 11 reserved.
// - Descriptor bits 8:5 pick one of sixteen domains.
// - Page table descriptor bits 31:10 give the page table base.
// - A page table descriptor triggers a second level fetch.
// - Section bits 3:2 give cacheable/bufferable, gated by cache and buffer enables.
// - Section bits 11:10 give permission, with system/rom bits, client domains only.
// - Code 00: none, supervisor read, read only, or reserved by protect bits.
// - Codes 01, 10, 11 grant supervisor, user read-only, full access.
// - Section physical bits 31:20 come from the descriptor, 1MB regions.
// - Permission check finishes before any translated address goes out.
// - Second level type: 00 fault, 01 large page, 10 small page, 11 reserved.
// - Page bit 2 bufferable, bit 3 cacheable, each gated by its enable.
// - Page bits 11:4 hold four sub-page permission codes.
// - Page number from bits 31:12 small, 31:16 large.
// - With the MMU off the virtual address passes out unchanged.
// - TLB holds 64 entries, replaced round robin.
// - Domain 00 and 10 fault, 01 checks permissions, 11 skips them.
`timescale 1ns/1ps
module mtw_walker #(
  parameter int TLB_ENTRIES = mtw_pkg::MTW_TLB_ENTRIES
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire mtw_pkg::mtw_cfg_write_type cfg_i,
  input wire mtw_pkg::mtw_request_type req_i,
  output logic req_ready_o,
  output mtw_pkg::mtw_response_type rsp_o,
  output logic mem_req_o,
  output logic [29:0] mem_word_addr_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  output logic [31:0] control_o,
  output logic [31:0] table_base_pointer_o,
  output logic [31:0] domain_access_o,
  output logic [7:0] fault_status_o,
  output logic [31:0] fault_addr_o
);
  import mtw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    mtw_walk_state_type fsm;
    logic [31:0] control;
    logic [17:0] base_hi;
    logic [31:0] dac;
    mtw_request_type req;
    mtw_tlb_entry_type ent;
    logic is_page;
    logic req_ready;
    mtw_response_type rsp;
    logic mem_req;
    logic [29:0] mem_addr;
    logic [7:0] fsr;
    logic [31:0] far;
  } mtw_walk_regs_type;

  mtw_walk_regs_type state_reg;
  mtw_walk_regs_type state_next;

  logic tlb_hit;
  mtw_tlb_entry_type tlb_entry;
  logic tlb_fill;
  mtw_tlb_entry_type tlb_fill_entry;
  logic tlb_flush;
  logic tlb_purge;

  ////////////////////////////////////////////////////////////////////////////
  // Permission decode for one two-bit code
  function automatic logic perm_ok(input logic [1:0] ap, input logic sys, input logic rom,
                                   input logic user, input logic write);
    logic ok;
    ok = 1'b0;
    unique case (ap)
      MTW_AP_PROT:
      begin
        unique case ({rom, sys})
          2'b00: ok = 1'b0;
          2'b01: ok = !user && !write;
          2'b10: ok = !write;
          2'b11: ok = 1'b0;
        endcase
      end
      MTW_AP_SUP: ok = !user;
      MTW_AP_USER_RO: ok = !user || !write;
      MTW_AP_FULL: ok = 1'b1;
    endcase
    return ok;
  endfunction : perm_ok

  // Select the two-bit field of one domain
  function automatic logic [1:0] dom_field(input logic [31:0] dac, input logic [3:0] idx);
    return dac[{idx, 1'b0} +: 2];
  endfunction : dom_field

  // Physical address from an entry and the untranslated offset
  function automatic logic [31:0] phys_addr(input mtw_tlb_entry_type ent, input logic [31:0] va);
    logic [31:0] pa;
    pa = {ent.ppn, va[11:0]};
    unique case (ent.kind)
      MTW_MAP_SECTION: pa = {ent.ppn[19:8], va[19:0]};
      MTW_MAP_LARGE: pa = {ent.ppn[19:4], va[15:0]};
      MTW_MAP_SMALL: pa = {ent.ppn, va[11:0]};
      default: pa = va;
    endcase
    return pa;
  endfunction : phys_addr

  // Sub-page permission code for the accessed address
  function automatic logic [1:0] sub_perm(input mtw_tlb_entry_type ent, input logic [31:0] va);
    logic [1:0] sel;
    sel = 2'b00;
    unique case (ent.kind)
      MTW_MAP_LARGE: sel = va[15:14];
      MTW_MAP_SMALL: sel = va[11:10];
      default: sel = 2'b00;
    endcase
    return ent.perm[{sel, 1'b0} +: 2];
  endfunction : sub_perm

  ////////////////////////////////////////////////////////////////////////////
  // TLB storage and lookup
  mtw_tlb #(
    .ENTRIES(TLB_ENTRIES)
  ) u_tlb (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .lookup_va_i(state_reg.req.vaddr),
    .lookup_hit_o(tlb_hit),
    .lookup_entry_o(tlb_entry),
    .fill_i(tlb_fill),
    .fill_entry_i(tlb_fill_entry),
    .flush_i(tlb_flush),
    .purge_i(tlb_purge),
    .purge_va_i(cfg_i.data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Walk sequencer and register writes
  always_comb
  begin
    logic [1:0] dom;
    logic [1:0] ap;
    logic ok;
    logic sys;
    logic rom;
    mtw_tlb_entry_type ent;
    dom = 2'b00;
    ap = 2'b00;
    ok = 1'b0;
    ent = '0;
    sys = state_reg.control[MTW_CTRL_SYS];
    rom = state_reg.control[MTW_CTRL_ROM];
    state_next = state_reg;
    state_next.rsp.valid = 1'b0;
    tlb_fill = 1'b0;
    tlb_fill_entry = '0;
    tlb_flush = 1'b0;
    tlb_purge = 1'b0;

    // Register writes; the table base drops its low bits on entry
    if (cfg_i.wr)
    begin
      unique case (cfg_i.sel)
        MTW_SEL_CONTROL: state_next.control = cfg_i.data;
        MTW_SEL_TABLE_BASE: state_next.base_hi = cfg_i.data[31:MTW_BASE_LSB];
        MTW_SEL_DOMAIN: state_next.dac = cfg_i.data;
        MTW_SEL_FLUSH: tlb_flush = 1'b1;
        MTW_SEL_PURGE: tlb_purge = 1'b1;
        default: ;
      endcase
    end

    unique case (state_reg.fsm)
      MTW_ST_IDLE:
      begin
        if (req_i.valid)
        begin
          state_next.req = req_i;
          state_next.req_ready = 1'b0;
          state_next.fsm = MTW_ST_LOOK;
        end
      end

      MTW_ST_LOOK:
      begin
        if (!state_reg.control[MTW_CTRL_MMU_EN])
        begin
          // Translation off: flat mapping, no checks
          state_next.rsp = '0;
          state_next.rsp.valid = 1'b1;
          state_next.rsp.paddr = state_reg.req.vaddr;
          state_next.req_ready = 1'b1;
          state_next.fsm = MTW_ST_IDLE;
        end
        else if (tlb_hit)
        begin
          state_next.ent = tlb_entry;
          state_next.is_page = (tlb_entry.kind != MTW_MAP_SECTION);
          state_next.fsm = MTW_ST_CHECK;
        end
        else
        begin
          state_next.mem_req = 1'b1;
          state_next.mem_addr = {state_reg.base_hi, state_reg.req.vaddr[31:20]};
          state_next.fsm = MTW_ST_L1;
        end
      end

      MTW_ST_L1:
      begin
        if (mem_ack_i)
        begin
          state_next.mem_req = 1'b0;
          state_next.ent.domain = mem_rdata_i[MTW_DOM_LSB +: 4];
          unique case (mem_rdata_i[1:0])
            MTW_L1_SECTION:
            begin
              ent.valid = 1'b1;
              ent.kind = MTW_MAP_SECTION;
              ent.vtag = {state_reg.req.vaddr[31:20], 8'h00};
              ent.ppn = {mem_rdata_i[31:20], 8'h00};
              ent.domain = mem_rdata_i[MTW_DOM_LSB +: 4];
              ent.cacheable = mem_rdata_i[MTW_DESC_C];
              ent.bufferable = mem_rdata_i[MTW_DESC_B];
              ent.perm = {4{mem_rdata_i[MTW_AP_LSB +: 2]}};
              tlb_fill = 1'b1;
              tlb_fill_entry = ent;
              state_next.ent = ent;
              state_next.is_page = 1'b0;
              state_next.fsm = MTW_ST_CHECK;
            end
            MTW_L1_PAGE:
            begin
              state_next.mem_req = 1'b1;
              state_next.mem_addr = {mem_rdata_i[31:MTW_PT_BASE_LSB], state_reg.req.vaddr[19:12]};
              state_next.is_page = 1'b1;
              state_next.fsm = MTW_ST_L2;
            end
            default:
            begin
              // Invalid or reserved descriptor
              state_next.rsp = '0;
              state_next.rsp.valid = 1'b1;
              state_next.rsp.fault = 1'b1;
              state_next.rsp.status = MTW_FS_TRANS_SECT;
              state_next.rsp.domain = mem_rdata_i[MTW_DOM_LSB +: 4];
              state_next.req_ready = 1'b1;
              state_next.fsm = MTW_ST_IDLE;
            end
          endcase
        end
      end

      MTW_ST_L2:
      begin
        if (mem_ack_i)
        begin
          state_next.mem_req = 1'b0;
          if ((mem_rdata_i[1:0] == MTW_L2_LARGE) || (mem_rdata_i[1:0] == MTW_L2_SMALL))
          begin
            ent.valid = 1'b1;
            ent.kind = (mem_rdata_i[1:0] == MTW_L2_LARGE) ? MTW_MAP_LARGE : MTW_MAP_SMALL;
            ent.vtag = state_reg.req.vaddr[31:12];
            ent.ppn = mem_rdata_i[31:12];
            ent.domain = state_reg.ent.domain;
            ent.cacheable = mem_rdata_i[MTW_DESC_C];
            ent.bufferable = mem_rdata_i[MTW_DESC_B];
            ent.perm = mem_rdata_i[MTW_SUBAP_LSB +: 8];
            tlb_fill = 1'b1;
            tlb_fill_entry = ent;
            state_next.ent = ent;
            state_next.fsm = MTW_ST_CHECK;
          end
          else
          begin
            state_next.rsp = '0;
            state_next.rsp.valid = 1'b1;
            state_next.rsp.fault = 1'b1;
            state_next.rsp.status = MTW_FS_TRANS_PAGE;
            state_next.rsp.domain = state_reg.ent.domain;
            state_next.req_ready = 1'b1;
            state_next.fsm = MTW_ST_IDLE;
          end
        end
      end

      MTW_ST_CHECK:
      begin
        // Address is released only after the domain check and, for client domains, the permission check pass
        dom = dom_field(state_reg.dac, state_reg.ent.domain);
        ap = sub_perm(state_reg.ent, state_reg.req.vaddr);
        ok = perm_ok(ap, sys, rom, state_reg.req.user, state_reg.req.write);
        state_next.rsp = '0;
        state_next.rsp.valid = 1'b1;
        state_next.rsp.domain = state_reg.ent.domain;
        state_next.req_ready = 1'b1;
        state_next.fsm = MTW_ST_IDLE;
        if ((dom == MTW_DOM_NONE) || (dom == MTW_DOM_RESVD))
        begin
          state_next.rsp.fault = 1'b1;
          state_next.rsp.status = state_reg.is_page ? MTW_FS_DOM_PAGE : MTW_FS_DOM_SECT;
        end
        else if ((dom == MTW_DOM_CLIENT) && !ok)
        begin
          state_next.rsp.fault = 1'b1;
          state_next.rsp.status = state_reg.is_page ? MTW_FS_PERM_PAGE : MTW_FS_PERM_SECT;
        end
        else
        begin
          state_next.rsp.paddr = phys_addr(state_reg.ent, state_reg.req.vaddr);
          state_next.rsp.cacheable = state_reg.ent.cacheable & state_reg.control[MTW_CTRL_CACHE_EN];
          state_next.rsp.bufferable = state_reg.ent.bufferable & state_reg.control[MTW_CTRL_WBUF_EN];
        end
      end

      default:
      begin
        state_next.fsm = MTW_ST_IDLE;
        state_next.req_ready = 1'b1;
        state_next.mem_req = 1'b0;
      end
    endcase

    // Only data aborts are recorded; instruction fetches may never execute
    if (state_next.rsp.valid && state_next.rsp.fault && state_reg.req.data)
    begin
      state_next.fsr = {state_next.rsp.domain, state_next.rsp.status};
      state_next.far = state_reg.req.vaddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_reg <= '0;
      state_reg.fsm <= MTW_ST_IDLE;
      state_reg.control <= MTW_CONTROL_RESET;
      state_reg.base_hi <= MTW_TABLE_BASE_RESET;
      state_reg.dac <= MTW_DOMAIN_RESET;
      state_reg.req_ready <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign req_ready_o = state_reg.req_ready;
  assign rsp_o = state_reg.rsp;
  assign mem_req_o = state_reg.mem_req;
  assign mem_word_addr_o = state_reg.mem_addr;
  assign control_o = state_reg.control;
  assign table_base_pointer_o = {state_reg.base_hi, MTW_BASE_ZERO};
  assign domain_access_o = state_reg.dac;
  assign fault_status_o = state_reg.fsr;
  assign fault_addr_o = state_reg.far;

endmodule : mtw_walker

// File: bench/mtw_mem_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Table memory: answers each descriptor fetch after lat cycles
module mtw_mem_model (
  input wire logic clk_i,
  input wire logic mem_req_o,
  input wire logic [29:0] mem_word_addr_o,
  output logic mem_ack_i,
  output logic [31:0] mem_rdata_i
);
  logic [31:0] mem [logic [29:0]];
  int lat = 0;
  int wait_n = 0;
  int n_fetch = 0;

  initial
  begin
    mem_ack_i = 1'b0;
    mem_rdata_i = 32'h0;
  end

  // Data toggles outside the ack so stale words never look valid
  always @(posedge clk_i)
  begin
    #1;
    if (mem_ack_i || !mem_req_o)
    begin
      mem_ack_i = 1'b0;
      wait_n = 0;
    end
    else if (wait_n == lat)
    begin
      mem_ack_i = 1'b1;
      mem_rdata_i = mem[mem_word_addr_o];
      n_fetch++;
    end
    else
      wait_n++;
    if (!mem_ack_i)
      mem_rdata_i = ~mem_rdata_i;
  end
endmodule : mtw_mem_model

// File: bench/mtw_walker_checker.sv
`timescale 1ns/1ps
module mtw_walker_checker
  import mtw_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire mtw_pkg::mtw_cfg_write_type cfg_i,
  input wire mtw_pkg::mtw_request_type req_i,
  input wire logic req_ready_o,
  input wire mtw_pkg::mtw_response_type rsp_o,
  input wire logic mem_req_o,
  input wire logic [29:0] mem_word_addr_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic [31:0] control_o,
  input wire logic [31:0] table_base_pointer_o,
  input wire logic [31:0] domain_access_o,
  input wire logic [7:0] fault_status_o,
  input wire logic [31:0] fault_addr_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  logic [31:0] va_q;
  logic l2_q;
  logic ack1;

  // Address under walk and level of the outstanding fetch
  always_ff @(posedge clk_i)
  begin
    if (req_i.valid && req_ready_o)
      va_q <= req_i.vaddr;
    if (srst_i)
      l2_q <= 1'b0;
    else if (mem_req_o && mem_ack_i)
      l2_q <= !l2_q && mem_rdata_i[1:0] == MTW_L1_PAGE;
  end
  assign ack1 = mem_req_o && mem_ack_i && !l2_q;

  sequence s_l1_ack(logic [1:0] t);
    ack1 && mem_rdata_i[1:0] == t;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  a_base_low: assert property (
    table_base_pointer_o[13:0] == 14'h0) else $error("base low bits set");
  a_base_write: assert property (
    cfg_i.wr && cfg_i.sel == MTW_SEL_TABLE_BASE |=> table_base_pointer_o[31:14] == $past(cfg_i.data[31:14]))
    else $error("base not written");
  a_off_pass: assert property (
    req_i.valid && req_ready_o && !control_o[MTW_CTRL_MMU_EN] |-> ##2 rsp_o.valid
    && rsp_o.paddr == $past(req_i.vaddr, 2)) else $error("passthrough wrong");
  a_l1_addr: assert property (
    $rose(mem_req_o) |-> mem_word_addr_o == {table_base_pointer_o[31:14], va_q[31:20]})
    else $error("first fetch address wrong");
  a_l2_addr: assert property (
    s_l1_ack(MTW_L1_PAGE) |=> mem_req_o && mem_word_addr_o == {$past(mem_rdata_i[31:10]), va_q[19:12]})
    else $error("second fetch address wrong");
  a_l1_fault: assert property (
    s_l1_ack(MTW_L1_FAULT) |=> rsp_o.valid && rsp_o.status == MTW_FS_TRANS_SECT)
    else $error("section translation fault missing");
  a_l2_fault: assert property (
    mem_req_o && mem_ack_i && l2_q && mem_rdata_i[1:0] == 2'b00 |=> rsp_o.valid && rsp_o.status == MTW_FS_TRANS_PAGE)
    else $error("page translation fault missing");
  a_sect_map: assert property (
    s_l1_ack(MTW_L1_SECTION) ##0 domain_access_o[{mem_rdata_i[8:5], 1'b0} +: 2] == MTW_DOM_MANAGER |-> ##2
    rsp_o.valid && !rsp_o.fault && rsp_o.paddr == {$past(mem_rdata_i[31:20], 2), va_q[19:0]}
    && rsp_o.domain == $past(mem_rdata_i[8:5], 2)) else $error("section mapping wrong");
  a_fetch_hold: assert property (
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_word_addr_o)) else $error("fetch dropped");
  a_fault_nopa: assert property (
    rsp_o.valid && rsp_o.fault |-> rsp_o.paddr == 32'h0) else $error("address out on fault");
endmodule : mtw_walker_checker

bind mtw_walker mtw_walker_checker chk_u (.clk_i, .srst_i, .cfg_i, .req_i, .req_ready_o, .rsp_o, .mem_req_o,
  .mem_word_addr_o, .mem_ack_i, .mem_rdata_i, .control_o, .table_base_pointer_o, .domain_access_o,
  .fault_status_o, .fault_addr_o);

// File: bench/tb_mmu_table_walk_decoder.sv
`timescale 1ns/1ps
module tb_mmu_table_walk_decoder;
  import mtw_pkg::*;
  logic clk_i;
  logic srst_i;
  mtw_cfg_write_type cfg_i;
  mtw_request_type req_i;
  logic req_ready_o;
  mtw_response_type rsp_o;
  logic mem_req_o;
  logic [29:0] mem_word_addr_o;
  logic mem_ack_i;
  logic [31:0] mem_rdata_i;
  logic [31:0] control_o;
  logic [31:0] table_base_pointer_o;
  logic [31:0] domain_access_o;
  logic [7:0] fault_status_o;
  logic [31:0] fault_addr_o;
  int n_mismatch = 0;
  int check_count = 0;
  int n;
  logic e;

  // Small TLB keeps replacement wrap reachable
  mtw_walker #(.TLB_ENTRIES(8)) dut_u (.clk_i, .srst_i, .cfg_i, .req_i, .req_ready_o, .rsp_o, .mem_req_o,
    .mem_word_addr_o, .mem_ack_i, .mem_rdata_i, .control_o, .table_base_pointer_o, .domain_access_o,
    .fault_status_o, .fault_addr_o);
  mtw_mem_model mem_u (.clk_i, .mem_req_o, .mem_word_addr_o, .mem_ack_i, .mem_rdata_i);

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic cfg(input logic [3:0] sel, input logic [31:0] d);
    @(negedge clk_i);
    cfg_i = '{1'b1, sel, d};
    @(negedge clk_i);
    cfg_i.wr = 1'b0;
  endtask : cfg

  // One translation; the walker is idle so the next edge takes it
  task automatic go(input logic [31:0] va, input logic u, input logic w, input logic [3:0] st,
                    input logic [31:0] pa, input logic [1:0] cb);
    int k;
    @(negedge clk_i);
    req_i = '{1'b1, va, w, u, 1'b1};
    @(negedge clk_i);
    req_i.valid = 1'b0;
    k = 0;
    while (rsp_o.valid !== 1'b1 && k < 40)
    begin
      @(negedge clk_i);
      k++;
    end
    chk("valid", 32'h1, 32'(rsp_o.valid));
    chk("status", 32'(st), 32'(rsp_o.status));
    chk("paddr", pa, rsp_o.paddr);
    chk("cb", 32'(cb), 32'({rsp_o.cacheable, rsp_o.bufferable}));
  endtask : go

  // Expected grant for a client access
  function automatic logic ok(input logic [1:0] ap, input logic s, input logic r, input logic u, input logic w);
    case (ap)
      2'b00: return !w && (s ? !u : r);
      2'b01: return !u;
      2'b10: return !u || !w;
      default: return 1'b1;
    endcase
  endfunction : ok

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    n_mismatch++;
    end_sim();
  end

  initial
  begin
    srst_i = 1'b1;
    cfg_i = '0;
    req_i = '0;
    // First level descriptors keep must-be-zero fields clear and bit 4 set
    mem_u.mem[30'h0004_0003] = 32'h5550_005e;
    mem_u.mem[30'h0004_0004] = 32'h6660_007e;
    mem_u.mem[30'h0004_0005] = 32'h0000_0010;
    mem_u.mem[30'h0004_0006] = 32'h0000_0013;
    mem_u.mem[30'h0004_0020] = 32'h0008_0031;
    mem_u.mem[30'h0002_0005] = 32'habcd_ec0a;
    mem_u.mem[30'h0002_000c] = 32'h1234_0405;
    mem_u.mem[30'h0002_0011] = 32'h0000_0000;
    for (int a = 0; a < 4; a++)
      mem_u.mem[30'h0004_0040 + 30'(a)] = {10'h0c0, 2'(a), 8'h00, 2'(a), 1'b0, 4'h1, 1'b1, 2'b11, 2'b10};
    repeat (8) @(negedge clk_i);
    srst_i = 1'b0;
    chk("ctrl", MTW_CONTROL_RESET, control_o);
    chk("dom", MTW_DOMAIN_RESET, domain_access_o);
    go(32'h1234_5678, 1'b0, 1'b1, MTW_FS_NONE, 32'h1234_5678, 2'b00);
    cfg(MTW_SEL_TABLE_BASE, 32'h0010_3fff);
    chk("base", 32'h0010_0000, table_base_pointer_o);
    cfg(MTW_SEL_DOMAIN, 32'h0000_0034);
    cfg(MTW_SEL_CONTROL, 32'h0000_000d);
    go(32'h0030_0abc, 1'b1, 1'b1, MTW_FS_NONE, 32'h5550_0abc, 2'b11);
    chk("domain", 32'h2, 32'(rsp_o.domain));
    n = mem_u.n_fetch;
    go(32'h0030_0abc, 1'b0, 1'b0, MTW_FS_NONE, 32'h5550_0abc, 2'b11);
    chk("fetches", 32'(n), 32'(mem_u.n_fetch));
    go(32'h0040_0010, 1'b0, 1'b0, MTW_FS_DOM_SECT, 32'h0, 2'b00);
    chk("fsr", 32'h39, 32'(fault_status_o));
    chk("far", 32'h0040_0010, fault_addr_o);
    go(32'h0050_0000, 1'b0, 1'b0, MTW_FS_TRANS_SECT, 32'h0, 2'b00);
    go(32'h0060_0000, 1'b0, 1'b0, MTW_FS_TRANS_SECT, 32'h0, 2'b00);
    mem_u.lat = 2;
    go(32'h0200_5c34, 1'b0, 1'b1, MTW_FS_NONE, 32'habcd_ec34, 2'b10);
    go(32'h0200_5034, 1'b1, 1'b0, MTW_FS_PERM_PAGE, 32'h0, 2'b00);
    go(32'h0200_c123, 1'b0, 1'b1, MTW_FS_NONE, 32'h1234_c123, 2'b01);
    go(32'h0200_c123, 1'b1, 1'b0, MTW_FS_PERM_PAGE, 32'h0, 2'b00);
    go(32'h0201_1000, 1'b0, 1'b0, MTW_FS_TRANS_PAGE, 32'h0, 2'b00);
    cfg(MTW_SEL_FLUSH, 32'h0);
    n = mem_u.n_fetch;
    go(32'h0030_0abc, 1'b0, 1'b0, MTW_FS_NONE, 32'h5550_0abc, 2'b11);
    chk("refetch", 32'(n + 1), 32'(mem_u.n_fetch));
    // Client sections across protect bits, modes and directions, caching off
    for (int sr = 0; sr < 3; sr++)
    begin
      cfg(MTW_SEL_CONTROL, 32'h1 | (32'(sr) << 8));
      for (int i = 0; i < 16; i++)
      begin
        e = ok(i[3:2], sr[0], sr[1], i[1], i[0]);
        go({10'h010, i[3:2], 20'h0}, i[1], i[0], e ? MTW_FS_NONE : MTW_FS_PERM_SECT,
           e ? {10'h0c0, i[3:2], 20'h0} : 32'h0, 2'b00);
      end
    end
    cfg(MTW_SEL_PURGE, 32'h0030_0000);
    n = mem_u.n_fetch;
    go(32'h0030_0abc, 1'b0, 1'b0, MTW_FS_NONE, 32'h5550_0abc, 2'b00);
    chk("purge", 32'(n + 1), 32'(mem_u.n_fetch));
    end_sim();
  end
endmodule : tb_mmu_table_walk_decoder
